/* ocd_defs.vh */
// constants shared by the instruction decoder files
// assumes inclusion by bare name from each design file
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH

// prefix and escape bytes
`define OCD_PFX_REPEAT_WHILE_UNEQUAL_PREFIX    8'hf2
`define OCD_PFX_REPEAT_WHILE_EQUAL_PREFIX     8'hf3
`define OCD_ESC_0F       8'h0f

// repeat prefix codes held with a decoded instruction
`define OCD_REP_NONE     2'h0
`define OCD_REP_UNEQ     2'h1
`define OCD_REP_EQ       2'h2

// highest condition code handled here
`define OCD_COND_MAX     4'h6

// decoded instruction classes
`define OCD_C_INVALID    5'h00
`define OCD_C_XOR_RM     5'h01
`define OCD_C_XOR_IMM    5'h02
`define OCD_C_XOR_ACC    5'h03
`define OCD_C_NOT        5'h04
`define OCD_C_STRING_COMPARE_OP       5'h05
`define OCD_C_STRING_LOAD_OP       5'h06
`define OCD_C_STRING_MOVE_OP       5'h07
`define OCD_C_INS        5'h08
`define OCD_C_PORT_STRING_OUTPUT_OP       5'h09
`define OCD_C_STRING_SCAN_OP       5'h0a
`define OCD_C_BSF        5'h0b
`define OCD_C_BSR        5'h0c
`define OCD_C_BT         5'h0d
`define OCD_C_BTC        5'h0e
`define OCD_C_BTR        5'h0f
`define OCD_C_BTS        5'h10
`define OCD_C_CALL_NEAR  5'h11
`define OCD_C_CALL_IND   5'h12
`define OCD_C_CALL_FIND  5'h13
`define OCD_C_JMP_SHORT  5'h14
`define OCD_C_JMP_NEAR   5'h15
`define OCD_C_JMP_FAR    5'h16
`define OCD_C_JMP_IND    5'h17
`define OCD_C_JMP_FIND   5'h18
`define OCD_C_RET_NEAR   5'h19
`define OCD_C_RET_FAR    5'h1a
`define OCD_C_JCC        5'h1b

// immediate kinds
`define OCD_K_NONE       3'h0
`define OCD_K_B1         3'h1
`define OCD_K_D8         3'h2
`define OCD_K_W16        3'h3
`define OCD_K_FULL       3'h4
`define OCD_K_WSIZE      3'h5
`define OCD_K_SW         3'h6
`define OCD_K_FAR        3'h7

// groups resolved by the mode byte middle field
`define OCD_G_NONE       3'h0
`define OCD_G_ARITH      3'h1
`define OCD_G_UNARY      3'h2
`define OCD_G_INDIR      3'h3
`define OCD_G_BITI       3'h4

// middle field values
`define OCD_R_010        3'h2
`define OCD_R_011        3'h3
`define OCD_R_100        3'h4
`define OCD_R_101        3'h5
`define OCD_R_110        3'h6
`define OCD_R_111        3'h7

// operand widths and byte counts
`define OCD_W_BYTE       2'h0
`define OCD_W_WORD       2'h1
`define OCD_W_DWORD      2'h2
`define OCD_N_0          3'h0
`define OCD_N_1          3'h1
`define OCD_N_2          3'h2
`define OCD_N_4          3'h4
`define OCD_N_6          3'h6
`define OCD_LANES        6

`endif

/* ocd_primary_map.v */
// one-byte opcode classifier, purely combinational
// assumes the caller strips prefixes and the 0f escape first
`include "ocd_defs.vh"

module ocd_primary_map (
    input  wire [7:0] opc,
    output reg  [4:0] cls,
    output reg        has_modrm,
    output reg  [2:0] kind,
    output reg  [2:0] grp,
    output reg        has_w
);

    // opcode table, unknown bytes fall to invalid
    always @*
    begin
        cls       = `OCD_C_INVALID;
        has_modrm = 1'b0;
        kind      = `OCD_K_NONE;
        grp       = `OCD_G_NONE;
        has_w     = 1'b0;
        casez (opc)
            8'b001100??:
            begin
                cls = `OCD_C_XOR_RM; has_modrm = 1'b1; has_w = 1'b1;
            end
            8'b0011010?:
            begin
                cls = `OCD_C_XOR_ACC; kind = `OCD_K_WSIZE; has_w = 1'b1;
            end
            8'b100000??:
            begin
                cls = `OCD_C_XOR_IMM; grp = `OCD_G_ARITH;
                has_modrm = 1'b1; kind = `OCD_K_SW; has_w = 1'b1;
            end
            8'b1111011?:
            begin
                cls = `OCD_C_NOT; grp = `OCD_G_UNARY;
                has_modrm = 1'b1; has_w = 1'b1;
            end
            8'b1010011?: begin cls = `OCD_C_STRING_COMPARE_OP; has_w = 1'b1; end
            8'b1010110?: begin cls = `OCD_C_STRING_LOAD_OP; has_w = 1'b1; end
            8'b1010010?: begin cls = `OCD_C_STRING_MOVE_OP; has_w = 1'b1; end
            8'b0110110?: begin cls = `OCD_C_INS;  has_w = 1'b1; end
            8'b0110111?: begin cls = `OCD_C_PORT_STRING_OUTPUT_OP; has_w = 1'b1; end
            8'b1010111?: begin cls = `OCD_C_STRING_SCAN_OP; has_w = 1'b1; end
            8'he8: begin cls = `OCD_C_CALL_NEAR; kind = `OCD_K_FULL; end
            8'hff:
            begin
                cls = `OCD_C_CALL_IND; grp = `OCD_G_INDIR;
                has_modrm = 1'b1;
            end
            8'heb: begin cls = `OCD_C_JMP_SHORT; kind = `OCD_K_D8; end
            8'he9: begin cls = `OCD_C_JMP_NEAR; kind = `OCD_K_FULL; end
            8'hea: begin cls = `OCD_C_JMP_FAR; kind = `OCD_K_FAR; end
            8'hc3: cls = `OCD_C_RET_NEAR;
            8'hcb: cls = `OCD_C_RET_FAR;
            8'hc2: begin cls = `OCD_C_RET_NEAR; kind = `OCD_K_W16; end
            8'hca: begin cls = `OCD_C_RET_FAR; kind = `OCD_K_W16; end
            8'b0111????:
                if (opc[3:0] <= `OCD_COND_MAX)
                begin
                    cls = `OCD_C_JCC; kind = `OCD_K_D8;
                end
            default: cls = `OCD_C_INVALID;
        endcase
    end

endmodule // ocd_primary_map

/* ocd_ext_map.v */
// classifier for the byte after the 0f escape, combinational
// assumes the caller has already consumed the escape byte
`include "ocd_defs.vh"

module ocd_ext_map (
    input  wire [7:0] opc,
    output reg  [4:0] cls,
    output reg        has_modrm,
    output reg  [2:0] kind,
    output reg  [2:0] grp
);

    // two-byte opcode table
    always @*
    begin
        cls       = `OCD_C_INVALID;
        has_modrm = 1'b1;
        kind      = `OCD_K_NONE;
        grp       = `OCD_G_NONE;
        casez (opc)
            8'hbc: cls = `OCD_C_BSF;
            8'hbd: cls = `OCD_C_BSR;
            8'ha3: cls = `OCD_C_BT;
            8'hbb: cls = `OCD_C_BTC;
            8'hb3: cls = `OCD_C_BTR;
            8'hab: cls = `OCD_C_BTS;
            8'hba:
            begin
                cls = `OCD_C_BT; grp = `OCD_G_BITI; kind = `OCD_K_B1;
            end
            8'b1000????:
            begin
                has_modrm = 1'b0;
                if (opc[3:0] <= `OCD_COND_MAX)
                begin
                    cls = `OCD_C_JCC; kind = `OCD_K_FULL;
                end
            end
            default:
            begin
                cls = `OCD_C_INVALID;
                has_modrm = 1'b0;
            end
        endcase
    end

endmodule // ocd_ext_map

/* ocd_decoder.v */
// instruction decoder for the logic, string, bit and branch subset
// assumes a byte stream with valid/ready from fetch, and an
// execution stage that accepts one decoded instruction at a time
`include "ocd_defs.vh"

// Overview of operation
// - xor reg/mem forms with mode byte
// - immediate xor when middle field is 110
// - accumulator xor, immediate follows opcode directly
// - invert when mode middle field is 010
// - compare, load, move strings, single byte
// - port string input and output, single byte
// - repeat prefix counts in 16/32-bit count register
// - repeated compare stops per prefix polarity
// - repeated scan stops per prefix polarity
// - bit scan forward/reverse, two-byte opcode, mode byte
// - bit test, immediate and register forms
// - bit test-complement, immediate and register forms
// - bit test-reset, immediate and register forms
// - bit test-set, immediate and register forms
// - direct and indirect calls
// - short, far and indirect unconditional jumps
// - returns, optional stack adjust immediate
// - conditional jumps short and long forms
// - condition codes zero to three
// - condition codes four and five
// - condition code six, below or equal
module ocd_decoder (
    input  wire        MCLK,
    input  wire        RST_B,
    input  wire        IN_VALID,
    input  wire [7:0]  IN_BYTE,
    output wire        IN_READY,
    input  wire        OPER32,
    input  wire        ADDR32,
    input  wire        EX_READY,
    output wire        OP_VALID,
    output wire        OP_INVALID,
    output wire [4:0]  OP_CLASS,
    output wire [1:0]  OP_WIDTH,
    output wire        OP_DIR,
    output wire [3:0]  OP_COND,
    output wire        OP_HAS_MODRM,
    output wire [7:0]  OP_MODRM,
    output wire [47:0] OP_IMM,
    output wire [1:0]  OP_REP,
    output wire        OP_COUNT32,
    output wire        OP_STOP_EQ,
    output wire        OP_STOP_NE,
    output wire        OP_SP_ADJ
);

    localparam [4:0] ST_OPC   = 5'h01;
    localparam [4:0] ST_OPC2  = 5'h02;
    localparam [4:0] ST_MODRM = 5'h04;
    localparam [4:0] ST_IMM   = 5'h08;
    localparam [4:0] ST_DONE  = 5'h10;

    reg  [4:0] state_r;
    reg  [4:0] class_r;
    reg        inv_r;
    reg        hasm_r;
    reg  [2:0] kind_r;
    reg  [2:0] grp_r;
    reg        hasw_r;
    reg        w_r;
    reg        s_r;
    reg        dir_r;
    reg  [3:0] cond_r;
    reg  [7:0] modrm_r;
    reg  [1:0] rep_r;
    reg        op32_r;
    reg        ad32_r;
    reg        sext_r;
    reg  [2:0] cnt_r;
    reg  [2:0] idx_r;

    wire [4:0] p_cls;
    wire       p_hasm;
    wire [2:0] p_kind;
    wire [2:0] p_grp;
    wire       p_hasw;
    wire [4:0] e_cls;
    wire       e_hasm;
    wire [2:0] e_kind;
    wire [2:0] e_grp;

    wire       take = IN_VALID & IN_READY;
    wire       in_ext = (state_r == ST_OPC2);

    // selected table entry for the byte being taken
    wire [4:0] sel_cls  = in_ext ? e_cls  : p_cls;
    wire       sel_hasm = in_ext ? e_hasm : p_hasm;
    wire [2:0] sel_kind = in_ext ? e_kind : p_kind;
    wire [2:0] sel_grp  = in_ext ? e_grp  : p_grp;
    wire       sel_hasw = in_ext ? 1'b0   : p_hasw;

    ocd_primary_map u_pri (
        .opc       (IN_BYTE),
        .cls       (p_cls),
        .has_modrm (p_hasm),
        .kind      (p_kind),
        .grp       (p_grp),
        .has_w     (p_hasw)
    );

    ocd_ext_map u_ext (
        .opc       (IN_BYTE),
        .cls       (e_cls),
        .has_modrm (e_hasm),
        .kind      (e_kind),
        .grp       (e_grp)
    );

    // immediate byte count for a kind and size
    function [2:0] imm_len;
        input [2:0] k;
        input       w;
        input       s;
        input       o32;
        begin
            case (k)
                `OCD_K_B1:    imm_len = `OCD_N_1;
                `OCD_K_D8:    imm_len = `OCD_N_1;
                `OCD_K_W16:   imm_len = `OCD_N_2;
                `OCD_K_FULL:  imm_len = o32 ? `OCD_N_4 : `OCD_N_2;
                `OCD_K_WSIZE: imm_len = !w ? `OCD_N_1 :
                                        (o32 ? `OCD_N_4 : `OCD_N_2);
                `OCD_K_SW:    imm_len = (s | !w) ? `OCD_N_1 :
                                        (o32 ? `OCD_N_4 : `OCD_N_2);
                `OCD_K_FAR:   imm_len = o32 ? `OCD_N_6 : `OCD_N_4;
                default:      imm_len = `OCD_N_0;
            endcase
        end
    endfunction

    // one signed byte widened across all six immediate lanes
    function sext_of;
        input [2:0] k;
        input       w;
        input       s;
        begin
            sext_of = (k == `OCD_K_D8) ||
                      ((k == `OCD_K_SW) && s && w);
        end
    endfunction

    // class picked by the mode byte middle field
    function [4:0] grp_cls;
        input [2:0] g;
        input [2:0] r;
        input [4:0] base;
        begin
            grp_cls = `OCD_C_INVALID;
            case (g)
                `OCD_G_NONE:  grp_cls = base;
                `OCD_G_ARITH:
                    if (r == `OCD_R_110)
                        grp_cls = `OCD_C_XOR_IMM;
                `OCD_G_UNARY:
                    if (r == `OCD_R_010)
                        grp_cls = `OCD_C_NOT;
                `OCD_G_INDIR:
                    case (r)
                        `OCD_R_010: grp_cls = `OCD_C_CALL_IND;
                        `OCD_R_011: grp_cls = `OCD_C_CALL_FIND;
                        `OCD_R_100: grp_cls = `OCD_C_JMP_IND;
                        `OCD_R_101: grp_cls = `OCD_C_JMP_FIND;
                        default:    grp_cls = `OCD_C_INVALID;
                    endcase
                `OCD_G_BITI:
                    case (r)
                        `OCD_R_100: grp_cls = `OCD_C_BT;
                        `OCD_R_111: grp_cls = `OCD_C_BTC;
                        `OCD_R_110: grp_cls = `OCD_C_BTR;
                        `OCD_R_101: grp_cls = `OCD_C_BTS;
                        default:    grp_cls = `OCD_C_INVALID;
                    endcase
                default: grp_cls = `OCD_C_INVALID;
            endcase
        end
    endfunction

    // string classes keep a repeat prefix, others drop it
    function is_string;
        input [4:0] c;
        begin
            is_string = (c == `OCD_C_STRING_COMPARE_OP) || (c == `OCD_C_STRING_LOAD_OP) ||
                        (c == `OCD_C_STRING_MOVE_OP) || (c == `OCD_C_INS)  ||
                        (c == `OCD_C_PORT_STRING_OUTPUT_OP) || (c == `OCD_C_STRING_SCAN_OP);
        end
    endfunction

    wire [4:0] m_cls = grp_cls(grp_r, IN_BYTE[5:3], class_r);
    wire [2:0] m_len = imm_len(kind_r, w_r, s_r, op32_r);
    wire [2:0] o_len = imm_len(sel_kind, IN_BYTE[0], IN_BYTE[1],
                               OPER32);

    // decode sequencer: prefixes, opcode, mode byte, immediate
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r <= ST_OPC;
            class_r <= `OCD_C_INVALID;
            inv_r   <= 1'b0;
            hasm_r  <= 1'b0;
            kind_r  <= `OCD_K_NONE;
            grp_r   <= `OCD_G_NONE;
            hasw_r  <= 1'b0;
            w_r     <= 1'b0;
            s_r     <= 1'b0;
            dir_r   <= 1'b0;
            cond_r  <= 4'h0;
            modrm_r <= 8'h00;
            rep_r   <= `OCD_REP_NONE;
            op32_r  <= 1'b0;
            ad32_r  <= 1'b0;
            sext_r  <= 1'b0;
            cnt_r   <= `OCD_N_0;
            idx_r   <= `OCD_N_0;
        end
        else
        begin
            case (state_r)
                ST_OPC, ST_OPC2:
                    if (take)
                    begin
                        if (!in_ext && IN_BYTE == `OCD_PFX_REPEAT_WHILE_UNEQUAL_PREFIX)
                            rep_r <= `OCD_REP_UNEQ;
                        else if (!in_ext && IN_BYTE == `OCD_PFX_REPEAT_WHILE_EQUAL_PREFIX)
                            rep_r <= `OCD_REP_EQ;
                        else if (!in_ext && IN_BYTE == `OCD_ESC_0F)
                            state_r <= ST_OPC2;
                        else
                        begin
                            class_r <= sel_cls;
                            hasm_r  <= sel_hasm;
                            kind_r  <= sel_kind;
                            grp_r   <= sel_grp;
                            hasw_r  <= sel_hasw;
                            w_r     <= IN_BYTE[0];
                            s_r     <= IN_BYTE[1];
                            dir_r   <= (sel_cls == `OCD_C_XOR_RM) &
                                       IN_BYTE[1];
                            cond_r  <= IN_BYTE[3:0];
                            op32_r  <= OPER32;
                            ad32_r  <= ADDR32;
                            sext_r  <= sext_of(sel_kind, IN_BYTE[0],
                                               IN_BYTE[1]);
                            idx_r   <= `OCD_N_0;
                            if (!is_string(sel_cls))
                                rep_r <= `OCD_REP_NONE;
                            if (sel_cls == `OCD_C_INVALID)
                            begin
                                inv_r   <= 1'b1;
                                state_r <= ST_DONE;
                            end
                            else if (sel_hasm)
                                state_r <= ST_MODRM;
                            else if (o_len == `OCD_N_0)
                                state_r <= ST_DONE;
                            else
                            begin
                                cnt_r   <= o_len;
                                state_r <= ST_IMM;
                            end
                        end
                    end
                ST_MODRM:
                    if (take)
                    begin
                        modrm_r <= IN_BYTE;
                        class_r <= m_cls;
                        // a bad middle field ends the instruction here,
                        // so no immediate bytes are swallowed
                        if (m_cls == `OCD_C_INVALID)
                        begin
                            inv_r   <= 1'b1;
                            state_r <= ST_DONE;
                        end
                        else if (m_len == `OCD_N_0)
                            state_r <= ST_DONE;
                        else
                        begin
                            cnt_r   <= m_len;
                            state_r <= ST_IMM;
                        end
                    end
                ST_IMM:
                    if (take)
                    begin
                        idx_r <= idx_r + `OCD_N_1;
                        cnt_r <= cnt_r - `OCD_N_1;
                        if (cnt_r == `OCD_N_1)
                            state_r <= ST_DONE;
                    end
                ST_DONE:
                    if (EX_READY)
                    begin
                        state_r <= ST_OPC;
                        inv_r   <= 1'b0;
                        rep_r   <= `OCD_REP_NONE;
                        modrm_r <= 8'h00;
                    end
                default: state_r <= ST_OPC;
            endcase
        end
    end

    // immediate lanes, little endian; a signed single byte
    // also fills every lane above it with its sign
    genvar gi;
    generate
        for (gi = 0; gi < `OCD_LANES; gi = gi + 1)
        begin : g_lane
            reg [7:0] lane_r;
            always @(posedge MCLK or negedge RST_B)
            begin
                if (!RST_B)
                    lane_r <= 8'h00;
                else if (state_r == ST_DONE && EX_READY)
                    lane_r <= 8'h00;
                else if (state_r == ST_IMM && take)
                begin
                    if (idx_r == gi)
                        lane_r <= IN_BYTE;
                    else if (sext_r && idx_r < gi)
                        lane_r <= {8{IN_BYTE[7]}};
                end
            end
            assign OP_IMM[8*gi +: 8] = lane_r;
        end
    endgenerate

    // no bytes are taken while a result waits for execution
    assign IN_READY     = (state_r != ST_DONE);
    assign OP_VALID     = (state_r == ST_DONE);
    assign OP_INVALID   = inv_r;
    assign OP_CLASS     = class_r;
    assign OP_DIR       = dir_r;
    assign OP_COND      = cond_r;
    assign OP_HAS_MODRM = hasm_r;
    assign OP_MODRM     = modrm_r;
    assign OP_REP       = rep_r;
    assign OP_COUNT32   = ad32_r;

    // width: byte when a w-bit opcode has its low bit clear, else operand size
    assign OP_WIDTH = (hasw_r && !w_r) ? `OCD_W_BYTE :
                      (op32_r ? `OCD_W_DWORD : `OCD_W_WORD);

    // repeated compare or scan stop polarity
    wire cmp_like = (class_r == `OCD_C_STRING_COMPARE_OP) ||
                    (class_r == `OCD_C_STRING_SCAN_OP);
    assign OP_STOP_EQ = cmp_like && (rep_r == `OCD_REP_UNEQ);
    assign OP_STOP_NE = cmp_like && (rep_r == `OCD_REP_EQ);

    // return with immediate: add it to the stack pointer after pop
    assign OP_SP_ADJ = ((class_r == `OCD_C_RET_NEAR) ||
                        (class_r == `OCD_C_RET_FAR)) &&
                       (kind_r == `OCD_K_W16);

    // condition codes above six stay out of this decoder

endmodule // ocd_decoder

/* ocd_fetch_model.sv */
// fetch unit and execution stage model facing the decoder
// assumes the bench calls feed on a falling clock edge
module ocd_fetch_model (
    input  wire        clk,
    input  wire        in_ready,
    output logic       in_valid,
    output logic [7:0] in_byte,
    output logic       ex_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow = 1'b0; // execution stalls every other cycle
    initial {in_valid, in_byte, ex_ready} = 10'h001;
    // stall pattern changes off the sampling edge
    always @(negedge clk)
        ex_ready <= slow ? ~ex_ready : 1'b1;
    // each byte held until the edge that takes it
    task automatic feed(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            in_valid = 1'b1;
            in_byte = b[i];
            while (in_ready !== 1'b1) @(negedge clk);
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_byte = ~in_byte; // released bus never shows the old byte
    endtask
endmodule // ocd_fetch_model

/* ocd_decoder_assertions.sv */
// concurrent checks on the decoded op outputs
// assumes one clock and the async active-low reset of the decoder
module ocd_decoder_assertions (
    input wire        MCLK,
    input wire        RST_B,
    input wire        IN_READY,
    input wire        EX_READY,
    input wire        OP_VALID,
    input wire        OP_INVALID,
    input wire [4:0]  OP_CLASS,
    input wire [3:0]  OP_COND,
    input wire [7:0]  OP_MODRM,
    input wire [47:0] OP_IMM,
    input wire [1:0]  OP_REP,
    input wire        OP_STOP_EQ,
    input wire        OP_STOP_NE,
    input wire        OP_SP_ADJ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);
    // op offered but execution not taking it yet
    sequence stall_s;
        OP_VALID && !EX_READY;
    endsequence
    wire       v = OP_VALID;
    wire [4:0] c = OP_CLASS;
    refuse_a: assert property (v |-> !IN_READY) else $error("byte taken");
    hold_a: assert property (stall_s |=> v && $stable(OP_IMM))
        else $error("op lost in stall");
    xor_imm_a: assert property (
        v && c == 5'h02 |-> OP_MODRM[5:3] == 3'h6) else $error("xor field");
    not_sel_a: assert property (
        v && c == 5'h04 |-> OP_MODRM[5:3] == 3'h2) else $error("not field");
    stop_a: assert property (
        v && (c == 5'h05 || c == 5'h0a) |-> OP_STOP_EQ == (OP_REP == 2'h1)
        && OP_STOP_NE == (OP_REP == 2'h2)) else $error("stop polarity");
    sp_adj_a: assert property (
        v |-> OP_SP_ADJ == ((c == 5'h19 || c == 5'h1a) && OP_COND[1:0] == 2'h2))
        else $error("stack adjust");
    inval_a: assert property (v |-> OP_INVALID == (c == 5'h00))
        else $error("invalid flag");
    jcc_a: assert property (v && c == 5'h1b |-> OP_COND <= 4'h6)
        else $error("condition range");
endmodule // ocd_decoder_assertions
bind ocd_decoder ocd_decoder_assertions chk_u (.MCLK, .RST_B, .IN_READY,
    .EX_READY, .OP_VALID, .OP_INVALID, .OP_CLASS, .OP_COND, .OP_MODRM,
    .OP_IMM, .OP_REP, .OP_STOP_EQ, .OP_STOP_NE, .OP_SP_ADJ);

/* ocd_decoder_tb_top.sv */
// self-checking bench for the instruction decoder
// assumes the fetch model and the bound checker are compiled with it
module ocd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       MCLK = 1'b0, RST_B = 1'b0, OPER32 = 1'b0, ADDR32 = 1'b0;
    wire        IN_VALID, IN_READY, EX_READY, OP_VALID, OP_INVALID, OP_DIR;
    wire        OP_HAS_MODRM, OP_COUNT32, OP_STOP_EQ, OP_STOP_NE, OP_SP_ADJ;
    wire [7:0]  IN_BYTE, OP_MODRM;
    wire [4:0]  OP_CLASS;
    wire [1:0]  OP_WIDTH, OP_REP;
    wire [3:0]  OP_COND;
    wire [47:0] OP_IMM;
    int         err_total = 0, n_checks = 0, cyc = 0;
    ocd_decoder dut_u (.MCLK, .RST_B, .IN_VALID, .IN_BYTE, .IN_READY,
        .OPER32, .ADDR32, .EX_READY, .OP_VALID, .OP_INVALID, .OP_CLASS,
        .OP_WIDTH, .OP_DIR, .OP_COND, .OP_HAS_MODRM, .OP_MODRM, .OP_IMM,
        .OP_REP, .OP_COUNT32, .OP_STOP_EQ, .OP_STOP_NE, .OP_SP_ADJ);
    ocd_fetch_model fm_u (.clk(MCLK), .in_ready(IN_READY),
        .in_valid(IN_VALID), .in_byte(IN_BYTE), .ex_ready(EX_READY));
    always #10 MCLK = ~MCLK;
    // whole run needs well under a thousand cycles
    always @(posedge MCLK)
        if (++cyc == 4000)
        begin
            err_total++;
            stop_test();
        end
    task automatic ck(input logic [47:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // send one instruction, then judge the op it decodes to
    task automatic op(input logic [7:0] b[$], input logic [4:0] c,
                      input logic [47:0] e);
        fm_u.feed(b);
        repeat (3) if (OP_VALID !== 1'b1) @(negedge MCLK);
        ck(OP_CLASS, c);
        ck(OP_IMM, e);
        ck(OP_INVALID, c == 5'h00);
    endtask
    task automatic t_logic();
        OPER32 = 1'b1;
        op({8'h33, 8'hc8}, 5'h01, 0);
        ck(OP_DIR, 1);
        op({8'h81, 8'hf0, 8'h44, 8'h33, 8'h22, 8'h11}, 5'h02,
            'h11223344);
        op({8'h83, 8'hf0, 8'h80}, 5'h02, 'hffffffffff80);
        ck(OP_WIDTH, 2);
        op({8'h34, 8'h7f}, 5'h03, 'h7f);
        ck(OP_WIDTH, 0);
        op({8'hf7, 8'hd0}, 5'h04, 0);
        ck(OP_MODRM, 'hd0);
        op({8'hf7, 8'hc0}, 5'h00, 0);
    endtask
    task automatic t_string();
        op({8'hf3, 8'ha7}, 5'h05, 0);
        ck(OP_STOP_NE, 1);
        ck(OP_REP, 2);
        op({8'hf2, 8'hae}, 5'h0a, 0);
        ck(OP_STOP_EQ, 1);
        ADDR32 = 1'b1;
        op({8'hf2, 8'hac}, 5'h06, 0);
        ck(OP_COUNT32, 1);
        ADDR32 = 1'b0;
        op({8'h6c}, 5'h08, 0);
        op({8'h6f}, 5'h09, 0);
    endtask
    // each bit test in its immediate index form by middle field, then its register form
    task automatic t_bits();
        logic [7:0] mf [4] = '{8'he0, 8'hf8, 8'hf0, 8'he8};
        logic [7:0] rf [4] = '{8'ha3, 8'hbb, 8'hb3, 8'hab};
        op({8'h0f, 8'hbd, 8'hc1}, 5'h0c, 0);
        ck(OP_HAS_MODRM, 1);
        for (int i = 0; i < 4; i++)
        begin
            op({8'h0f, 8'hba, mf[i], 8'h85}, 5'(13 + i), 'h85);
            op({8'h0f, rf[i], 8'hc1}, 5'(13 + i), 0);
        end
        op({8'h0f, 8'hba, 8'hc0}, 5'h00, 0);
    endtask
    // execution stalls here so held ops are exercised
    task automatic t_branch();
        fm_u.slow = 1'b1;
        OPER32 = 1'b0; // 16-bit displacements below
        op({8'he8, 8'h34, 8'h12}, 5'h11, 'h1234);
        op({8'hff, 8'hd8}, 5'h13, 0);
        op({8'heb, 8'h80}, 5'h14, 'hffffffffff80);
        op({8'hff, 8'he8}, 5'h18, 0);
        op({8'hc2, 8'h34, 8'h12}, 5'h19, 'h1234);
        ck(OP_SP_ADJ, 1);
        for (logic [7:0] c = 8'h00; c < 8'h07; c++)
        begin
            op({8'h70 | c, 8'hfe}, 5'h1b, 'hfffffffffffe);
            op({8'h0f, 8'h80 | c, 8'h34, 8'h12}, 5'h1b, 'h1234);
            ck(OP_COND, c);
        end
        op({8'h77}, 5'h00, 0);
    endtask
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", err_total, n_checks);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(negedge MCLK);
        RST_B = 1'b1;
        t_logic();
        t_string();
        t_bits();
        t_branch();
        stop_test();
    end
endmodule // ocd_decoder_tb_top
